// ===== adc_source.sv
/*
  Model of the ADC pixel stream: offers queued words on valid/ready.
  Assumes the bench fills pend and drives slow; changes at falling edge.
*/
`timescale 1ns/1ps
module adc_source (
  input wire logic clock,
  input wire logic slow,
  input wire logic pix_ready,
  output logic pix_valid,
  output logic [9:0] pix_data,
  output logic [1:0] pix_color,
  output logic pix_dark_col,
  output logic pix_dark_row,
  output logic [3:0] dark_row_index
);
  logic [17:0] pend[$];
  logic took = 1'b0;
  initial begin
    pix_valid = 1'b0;
    {pix_data, pix_color, pix_dark_col, pix_dark_row, dark_row_index} = 0;
  end
  // note a transfer at the sampling edge
  always @(posedge clock) took <= pix_valid && pix_ready;
  // hold each word until taken; idle data toggles so it is never stale
  always @(negedge clock) begin
    if (took) void'(pend.pop_front());
    if (pend.size() > 0 && !(slow && (took || !pix_valid)
        && $urandom_range(1) == 0)) begin
      pix_valid <= 1'b1;
      {pix_data, pix_color, pix_dark_col, pix_dark_row,
        dark_row_index} <= pend[0];
    end else begin
      pix_valid <= 1'b0;
      pix_data <= ~pix_data;
    end
  end
endmodule : adc_source

// ===== pixel_fifo.sv
/*
  Pixel FIFO with a registered read port (show-ahead output register).
  Assumes one clock, synchronous active-low reset, and that the writer
  honours in_ready.
*/
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 8 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("pixel_fifo depth must be a power of two of at least 8");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic push;
  logic pop;

  // a word moves to the output register when it is empty or being taken
  assign push = in_valid && (count_ff != DEPTH[AW:0]);
  assign pop = (count_ff != '0) && (!out_valid_ff || out_ready);
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;
  assign level = count_ff;

  // storage array, no reset needed
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // output register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff <= mem_ff[rd_ptr_ff];
    end else if (out_ready) begin
      out_valid_ff <= 1'b0;
    end
  end

endmodule : pixel_fifo

// ===== row_noise_correct.sv
/*
  Row-noise cancellation and black-level average path of the sensor core.
  Holds the correction registers, averages dark columns per row and dark
  rows per frame per colour, corrects each pixel and queues it in a FIFO.
  Assumes the ADC stream is on this clock, dark columns lead each row with
  2**DCOL_LOG2 samples per colour, and frame_start precedes the dark rows.
*/
`timescale 1ns/1ps
module row_noise_correct
  import row_noise_pkg::*;
#(
  parameter int DCOL_LOG2 = 2,
  parameter int DROW_LOG2 = 4,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [7:0] analog_gain_upper,
  input wire logic row_readout_enable_setting,
  input wire logic frame_start,
  input wire logic row_start,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [9:0] pix_data,
  input wire logic [1:0] pix_color,
  input wire logic pix_dark_col,
  input wire logic pix_dark_row,
  input wire logic [3:0] dark_row_index,
  output logic out_valid,
  input wire logic out_ready,
  output logic [9:0] out_data,
  output logic [1:0] out_color,
  output logic sweep_disable,
  output logic recalc_pulse
);

  if (DCOL_LOG2 < 0 || DCOL_LOG2 > 6 || DROW_LOG2 < 1 || DROW_LOG2 > 8)
  begin : g_bad_params
    $error("row_noise_correct: averaging sizes out of range");
  end

  localparam int CSW = 10 + DCOL_LOG2;
  localparam int RSW = 10 + DROW_LOG2;
  localparam int FAW = $clog2(FIFO_DEPTH);

  logic [15:0] row_noise_control_ff;
  logic [7:0] dark_row_select_ff;
  logic [15:0] black_target_window_ff;
  logic [15:0] calibration_control_ff;
  logic [15:0] reg_rdata_ff;
  logic recalc_ff;
  logic [6:0] frame_avg_ff [4];
  logic [CSW-1:0] col_sum_ff [4];
  logic [3:0] col_fresh_ff;
  logic [RSW-1:0] row_sum_ff [4];
  logic [DROW_LOG2:0] row_cnt_ff [4];
  logic [2:0] rows_seen_ff;
  logic pix_ready_ff;
  logic stage_valid_ff;
  logic [11:0] stage_data_ff;
  logic [FAW:0] fifo_level;
  logic fifo_in_ready;
  logic take;
  logic col_update;
  logic row_use;
  logic [9:0] col_avg;
  logic [1:0] gain_upper;
  logic high_gain;
  logic [6:0] window_mean;
  logic [9:0] subtract;
  logic signed [12:0] corrected;
  logic [9:0] result;
  logic [11:0] fifo_out_data;

  assign take = pix_valid && pix_ready_ff;
  assign reg_rdata = reg_rdata_ff;
  assign pix_ready = pix_ready_ff;
  assign sweep_disable = calibration_control_ff[BIT_SWEEP_DISABLE];
  assign recalc_pulse = recalc_ff;
  assign out_data = fifo_out_data[9:0]; // fifo word is colour over pixel
  assign out_color = fifo_out_data[11:10];

  // register writes; recalculate bit is write-one and reads back zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      row_noise_control_ff <= RST_ROW_NOISE_CONTROL;
      dark_row_select_ff <= RST_DARK_ROW_SELECT[7:0];
      black_target_window_ff <= RST_BLACK_TARGET_WINDOW;
      calibration_control_ff <= RST_CALIBRATION_CONTROL;
      recalc_ff <= 1'b0;
    end else begin
      recalc_ff <= 1'b0;
      if (reg_wr) begin
        unique case (reg_addr)
          ADDR_ROW_NOISE_CONTROL: row_noise_control_ff <= reg_wdata;
          ADDR_DARK_ROW_SELECT: dark_row_select_ff <= reg_wdata[7:0];
          ADDR_BLACK_TARGET_WINDOW: begin
            black_target_window_ff <= reg_wdata & 16'h7f7f;
          end
          ADDR_CALIBRATION_CONTROL: begin
            calibration_control_ff <= reg_wdata & 16'hefff;
            recalc_ff <= reg_wdata[BIT_RECALC];
          end
          default: ;
        endcase
      end
    end
  end

  // register reads, answered one cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_ROW_NOISE_CONTROL: reg_rdata_ff <= row_noise_control_ff;
        ADDR_DARK_ROW_SELECT: reg_rdata_ff <= {8'h00, dark_row_select_ff};
        ADDR_GREEN1_BLACK_AVERAGE: begin
          reg_rdata_ff <= {9'h000, frame_avg_ff[COLOR_GREEN1]};
        end
        ADDR_BLUE_BLACK_AVERAGE: begin
          reg_rdata_ff <= {9'h000, frame_avg_ff[COLOR_BLUE]};
        end
        ADDR_RED_BLACK_AVERAGE: begin
          reg_rdata_ff <= {9'h000, frame_avg_ff[COLOR_RED]};
        end
        ADDR_GREEN2_BLACK_AVERAGE: begin
          reg_rdata_ff <= {9'h000, frame_avg_ff[COLOR_GREEN2]};
        end
        ADDR_BLACK_TARGET_WINDOW: reg_rdata_ff <= black_target_window_ff;
        ADDR_CALIBRATION_CONTROL: reg_rdata_ff <= calibration_control_ff;
        default: reg_rdata_ff <= 16'h0000;
      endcase
    end
  end

  // rows since frame start, saturating once the frame-wise rows are past
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rows_seen_ff <= 3'h0;
    end else if (frame_start) begin
      rows_seen_ff <= 3'h0;
    end else if (row_start && rows_seen_ff <= FRAME_WISE_ROWS) begin
      rows_seen_ff <= rows_seen_ff + 3'h1;
    end
  end

  // per-row dark column averaging; frame-wise mode freezes after two pairs
  assign col_update = !row_noise_control_ff[BIT_FRAME_WISE] ||
                      (rows_seen_ff <= FRAME_WISE_ROWS);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      col_fresh_ff <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        col_sum_ff[c] <= '0;
      end
    end else begin
      if (row_start) begin
        col_fresh_ff <= {4{col_update}};
      end else if (take && pix_dark_col && col_fresh_ff[pix_color]) begin
        col_fresh_ff[pix_color] <= 1'b0;
      end
      if (!row_start && take && pix_dark_col && col_update) begin
        if (col_fresh_ff[pix_color]) begin
          col_sum_ff[pix_color] <= CSW'(pix_data);
        end else begin
          col_sum_ff[pix_color] <= col_sum_ff[pix_color] + CSW'(pix_data);
        end
      end
    end
  end

  // dark-row sample collection, masked rows only when their readout is on
  assign row_use = pix_dark_row && row_readout_enable_setting &&
                   (dark_row_index < 4'(MASKED_DARK_ROWS)) &&
                   dark_row_select_ff[dark_row_index[2:0]];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int c = 0; c < 4; c++) begin
        row_sum_ff[c] <= '0;
        row_cnt_ff[c] <= '0;
      end
    end else if (frame_start) begin
      for (int c = 0; c < 4; c++) begin
        row_sum_ff[c] <= '0;
        row_cnt_ff[c] <= '0;
      end
    end else if (take && row_use && !row_cnt_ff[pix_color][DROW_LOG2]) begin
      row_sum_ff[pix_color] <= row_sum_ff[pix_color] + RSW'(pix_data);
      row_cnt_ff[pix_color] <= row_cnt_ff[pix_color] + 1'b1;
    end
  end

  // frame averages move only at frame start, from the previous frame
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int c = 0; c < 4; c++) begin
        frame_avg_ff[c] <= 7'h00;
      end
    end else if (frame_start) begin
      for (int c = 0; c < 4; c++) begin
        if (row_cnt_ff[c][DROW_LOG2]) begin
          if (row_sum_ff[c][RSW-1:DROW_LOG2+7] != '0) begin
            frame_avg_ff[c] <= 7'h7f;
          end else begin
            frame_avg_ff[c] <= row_sum_ff[c][DROW_LOG2+6:DROW_LOG2];
          end
        end
      end
    end
  end

  // choose the subtracted value for this pixel's colour
  assign gain_upper = analog_gain_upper[2*pix_color +: 2];
  assign high_gain = {1'b0, gain_upper} >=
                     row_noise_control_ff[THRESH_MSB:THRESH_LSB];
  assign col_avg = col_sum_ff[pix_color][CSW-1:DCOL_LOG2];
  assign window_mean = 7'(({1'b0, black_target_window_ff[UPPER_MSB:UPPER_LSB]}
                       + {1'b0, black_target_window_ff[LOWER_MSB:0]}) >> 1);
  always_comb begin
    if (high_gain) begin
      subtract = col_avg;
    end else if (row_noise_control_ff[BIT_USE_BLACK_AVG]) begin
      subtract = {3'h0, frame_avg_ff[pix_color]};
    end else begin
      subtract = {3'h0, window_mean};
    end
  end

  // subtract, add constant, clamp to the ADC range
  assign corrected = $signed({3'h0, pix_data}) - $signed({3'h0, subtract})
                   + $signed({3'h0, row_noise_control_ff[CONST_MSB:0]});
  always_comb begin
    if (!row_noise_control_ff[BIT_CORR_ENABLE]) begin
      result = pix_data;
    end else if (corrected < 0) begin
      result = 10'h000;
    end else if (corrected > 13'sd1023) begin
      result = 10'h3ff;
    end else begin
      result = corrected[9:0];
    end
  end

  // one pipeline stage into the FIFO; ready keeps room for words in flight
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage_valid_ff <= 1'b0;
      stage_data_ff <= 12'h000;
      pix_ready_ff <= 1'b0;
    end else begin
      stage_valid_ff <= take;
      if (take) begin
        stage_data_ff <= {pix_color, result};
      end
      pix_ready_ff <= fifo_in_ready &&
                      (fifo_level <= (FAW+1)'(FIFO_DEPTH - 4));
    end
  end

  // output queue
  pixel_fifo #(
    .WIDTH(12),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(stage_valid_ff),
    .in_ready(fifo_in_ready),
    .in_data(stage_data_ff),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

endmodule : row_noise_correct

// ===== row_noise_monitor.sv
/*
  Port checker for row_noise_correct, bound to every instance.
  Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module row_noise_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [9:0] out_data,
  input wire logic [1:0] out_color,
  input wire logic sweep_disable,
  input wire logic recalc_pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // register port
  sweep_bit_a: assert property (reg_wr && reg_addr == 8'h60
    |=> sweep_disable == $past(reg_wdata[15])) else $error("sweep bit lost");
  recalc_once_a: assert property (reg_wr && reg_addr == 8'h60
    && reg_wdata[12] |=> recalc_pulse ##1 !recalc_pulse)
    else $error("recalc pulse wrong");
  avg_ro_a: assert property (reg_rd && reg_addr >= 8'h5b
    && reg_addr <= 8'h5e |=> reg_rdata[15:7] == 9'h000)
    else $error("average wider than 7 bits");
  window_read_a: assert property (reg_wr && reg_addr == 8'h5f
    ##2 reg_rd && reg_addr == 8'h5f
    |=> reg_rdata == ($past(reg_wdata, 3) & 16'h7f7f))
    else $error("target window readback wrong");
  mask_read_a: assert property (reg_rd && reg_addr == 8'h59
    |=> reg_rdata[15:8] == 8'h00) else $error("mask upper byte set");
  ctrl_read_a: assert property (reg_wr && reg_addr == 8'h30
    ##2 reg_rd && reg_addr == 8'h30 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("control readback wrong");
  // pixel path
  hold_out_a: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_data) && $stable(out_color))
    else $error("output changed while stalled");
  take_out_a: assert property (pix_valid && pix_ready
    |-> ##[1:4] out_valid) else $error("taken pixel never queued");
  cover property (reg_wr && reg_addr == 8'h30);
  cover property (out_valid && !out_ready ##1 out_valid && out_ready);
  cover property (!pix_ready);
endmodule : row_noise_monitor

bind row_noise_correct row_noise_monitor mon (.clock(clock),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
  .pix_ready(pix_ready), .out_valid(out_valid), .out_ready(out_ready),
  .out_data(out_data), .out_color(out_color),
  .sweep_disable(sweep_disable), .recalc_pulse(recalc_pulse));

// ===== row_noise_pkg.sv
/*
  Constants shared by the row-noise and black-level correction path:
  register offsets, field positions, reset values and colour codes.
  Assumes an 8-bit register address and 16-bit register data.
*/
package row_noise_pkg;

  // register offsets on the sensor-core register port
  localparam logic [7:0] ADDR_ROW_NOISE_CONTROL = 8'h30;
  localparam logic [7:0] ADDR_DARK_ROW_SELECT = 8'h59;
  localparam logic [7:0] ADDR_GREEN1_BLACK_AVERAGE = 8'h5b;
  localparam logic [7:0] ADDR_BLUE_BLACK_AVERAGE = 8'h5c;
  localparam logic [7:0] ADDR_RED_BLACK_AVERAGE = 8'h5d;
  localparam logic [7:0] ADDR_GREEN2_BLACK_AVERAGE = 8'h5e;
  localparam logic [7:0] ADDR_BLACK_TARGET_WINDOW = 8'h5f;
  localparam logic [7:0] ADDR_CALIBRATION_CONTROL = 8'h60;

  // reset values
  localparam logic [15:0] RST_ROW_NOISE_CONTROL = 16'h042a;
  localparam logic [15:0] RST_DARK_ROW_SELECT = 16'h00ff;
  localparam logic [15:0] RST_BLACK_TARGET_WINDOW = 16'h231d;
  localparam logic [15:0] RST_CALIBRATION_CONTROL = 16'h0080;

  // row_noise_control fields
  localparam int BIT_FRAME_WISE = 15;
  localparam int THRESH_MSB = 14;
  localparam int THRESH_LSB = 12;
  localparam int BIT_USE_BLACK_AVG = 11;
  localparam int BIT_CORR_ENABLE = 10;
  localparam int CONST_MSB = 9;

  // black_target_window fields
  localparam int UPPER_MSB = 14;
  localparam int UPPER_LSB = 8;
  localparam int LOWER_MSB = 6;

  // calibration_control fields
  localparam int BIT_SWEEP_DISABLE = 15;
  localparam int BIT_RECALC = 12;

  // dark rows that the mask can select, and rows used in frame-wise mode
  localparam int MASKED_DARK_ROWS = 8;
  localparam logic [2:0] FRAME_WISE_ROWS = 3'h4;

  // colour codes on the pixel stream
  typedef enum logic [1:0] {
    COLOR_GREEN1 = 2'h0,
    COLOR_BLUE = 2'h1,
    COLOR_RED = 2'h2,
    COLOR_GREEN2 = 2'h3
  } color_type;

endpackage : row_noise_pkg

// ===== testbench.sv
/*
  Self-checking bench for row_noise_correct with the ADC stream model.
  Assumes a 50 ns clock; expected pixels queue up in exp_q.
*/
`timescale 1ns/1ps
module testbench;
  import row_noise_pkg::*;
  localparam int COL_N = 4;
  localparam int ROW_N = 16;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [7:0] analog_gain_upper = 8'h00;
  logic frame_start = 1'b0;
  logic row_start = 1'b0;
  logic pix_valid, pix_ready, pix_dark_col, pix_dark_row;
  logic [9:0] pix_data, out_data;
  logic [1:0] pix_color, out_color;
  logic [3:0] dark_row_index;
  logic out_valid, sweep_disable, recalc_pulse;
  logic out_ready = 1'b0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic row_readout = 1'b1;
  logic [15:0] want;
  logic [11:0] exp_q[$];
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  always #25 clock = ~clock;

  row_noise_correct #(.DCOL_LOG2(2), .DROW_LOG2(4), .FIFO_DEPTH(16)) dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .analog_gain_upper(analog_gain_upper),
    .row_readout_enable_setting(row_readout), .frame_start(frame_start),
    .row_start(row_start), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_data(pix_data), .pix_color(pix_color),
    .pix_dark_col(pix_dark_col), .pix_dark_row(pix_dark_row),
    .dark_row_index(dark_row_index), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_color(out_color),
    .sweep_disable(sweep_disable), .recalc_pulse(recalc_pulse));

  adc_source adc (.clock(clock), .slow(slow), .pix_ready(pix_ready),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_color(pix_color),
    .pix_dark_col(pix_dark_col), .pix_dark_row(pix_dark_row),
    .dark_row_index(dark_row_index));

  task automatic print_verdict;
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [15:0] seen,
      input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    @(negedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    check("reg_rdata", reg_rdata, e);
    @(negedge clock);
  endtask : rd

  task automatic pix(input int d, input int c, input logic dc, dr,
      input int idx, input int e);
    adc.pend.push_back({d[9:0], c[1:0], dc, dr, idx[3:0]});
    exp_q.push_back({c[1:0], e[9:0]});
  endtask : pix

  task automatic pulse(input logic frame);
    if (frame) frame_start = 1'b1;
    else row_start = 1'b1;
    @(negedge clock);
    frame_start = 1'b0;
    row_start = 1'b0;
    @(negedge clock);
  endtask : pulse

  task automatic drain;
    while (exp_q.size() > 0) @(negedge clock);
  endtask : drain

  // pixel minus dark level plus constant, clipped to the adc range
  function automatic int fix(input int p, input int s);
    int v;
    v = p - s + 42;
    if (v < 0) v = 0;
    if (v > 1023) v = 1023;
    return v;
  endfunction : fix

  // sink side: random stalls, unless the bench holds the fifo full
  always @(negedge clock) out_ready <= !hold && $urandom_range(3) != 0;

  // compare each delivered pixel with the oldest note; cut hangs short
  always @(posedge clock) begin
    cycles++;
    if (cycles > 6000) begin
      failures++;
      print_verdict();
    end else if (rst_n && out_valid && out_ready) begin
      want = exp_q.size() > 0 ? {4'h0, exp_q.pop_front()} : 16'hffff;
      check("pixel", {4'h0, out_color, out_data}, want);
    end
  end

  initial begin
    void'($urandom(32'h76ca_ee76));
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    rd(8'h30, 16'h042a);
    rd(8'h59, 16'h00ff);
    rd(8'h5f, 16'h231d);
    wr(8'h5b, 16'hffff);
    rd(8'h5b, 16'h0000);
    rd(8'h42, 16'h0000);
    wr(8'h5f, 16'hffff);
    rd(8'h5f, 16'h7f7f);
    wr(8'h5f, 16'h231d);
    wr(8'h60, 16'h9080);
    rd(8'h60, 16'h8080);
    check("sweep_disable", {15'h0, sweep_disable}, 16'h0001);
    wr(8'h59, 16'hfffd);
    rd(8'h59, 16'h00fd);
    // dark rows with correction off: green1 row 0 kept, blue row 1 masked
    wr(8'h30, 16'h002a);
    pulse(1'b1);
    for (int i = 0; i < ROW_N; i++) begin
      pix(50, 0, 1'b0, 1'b1, 0, 50);
      pix(60, 1, 1'b0, 1'b1, 1, 60);
    end
    drain();
    rd(8'h5b, 16'h0000);
    pulse(1'b1);
    rd(8'h5b, 16'h0032);
    rd(8'h5c, 16'h0000);
    // dark-row readout off: no samples taken, average kept
    row_readout = 1'b0;
    for (int i = 0; i < ROW_N; i++) begin
      pix(90, 0, 1'b0, 1'b1, 0, 90);
    end
    drain();
    pulse(1'b1);
    rd(8'h5b, 16'h0032);
    row_readout = 1'b1;
    // one row: green1 at threshold, blue below it
    wr(8'h30, 16'h202a);
    analog_gain_upper = 8'b0000_0110;
    pulse(1'b0);
    for (int i = 0; i < COL_N; i++) begin
      pix(100, 0, 1'b1, 1'b0, 0, 100);
      pix(100, 1, 1'b1, 1'b0, 0, 100);
    end
    drain();
    wr(8'h30, 16'h242a);
    rd(8'h30, 16'h242a);
    pix(500, 0, 1'b0, 1'b0, 0, fix(500, 100));
    pix(40, 0, 1'b0, 1'b0, 0, fix(40, 100));
    pix(500, 1, 1'b0, 1'b0, 0, fix(500, 32));
    pix(1023, 1, 1'b0, 1'b0, 0, fix(1023, 32));
    drain();
    // low gain everywhere, frame average as the dark level
    wr(8'h30, 16'h3c2a);
    pix(200, 0, 1'b0, 1'b0, 0, fix(200, 50));
    pix(200, 1, 1'b0, 1'b0, 0, fix(200, 0));
    drain();
    // frame-wise: the fourth row still updates, the fifth is frozen
    wr(8'h30, 16'h802a);
    pulse(1'b1);
    for (int r = 0; r < 5; r++) begin
      pulse(1'b0);
      for (int i = 0; i < COL_N && r >= 3; i++) begin
        pix(r == 3 ? 120 : 200, 0, 1'b1, 1'b0, 0, r == 3 ? 120 : 200);
      end
      drain();
    end
    wr(8'h30, 16'ha42a);
    pix(500, 0, 1'b0, 1'b0, 0, fix(500, 120));
    drain();
    // fill the fifo until it refuses, then drain with stalls both sides
    wr(8'h30, 16'h002a);
    slow = 1'b1;
    hold = 1'b1;
    for (int i = 0; i < 24; i++) begin
      pix($urandom_range(1023), i % 4, 1'b0, 1'b0, 0, 0);
      exp_q[exp_q.size() - 1][9:0] = adc.pend[adc.pend.size() - 1][17:8];
    end
    repeat (80) @(negedge clock);
    check("pix_ready", {15'h0, pix_ready}, 16'h0000);
    hold = 1'b0;
    drain();
    print_verdict();
  end
endmodule : testbench
